/* design/arl_avg.sv */
// sample averager: running sum over a channel, mean on the last sample
`timescale 1ns/1ps
module arl_avg import arl_pkg::*; #(
  parameter int RES_W = ARL_RES_W,
  parameter int N = ARL_AVG_N
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // control
  input wire logic clear,
  input wire logic avg_en,
  // samples in
  input wire logic sample_valid,
  input wire logic [RES_W-1:0] sample,
  // result, valid together with the sample it completes
  output logic last,
  output logic [RES_W-1:0] mean
);
  localparam int SH = $clog2(N);
  logic [RES_W+SH-1:0] acc;
  logic [SH-1:0] cnt;
  wire [RES_W+SH-1:0] sum = acc + {{SH{1'b0}}, sample};
  // mean truncates; N is a power of two so a shift divides exactly
  assign last = !avg_en || (cnt == SH'(N - 1));
  assign mean = avg_en ? sum[RES_W+SH-1:SH] : sample;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= '0;
      cnt <= '0;
    end else if (ce) begin
      if (clear || (sample_valid && last)) begin
        acc <= '0;
        cnt <= '0;
      end else if (sample_valid) begin
        acc <= sum;
        cnt <= cnt + SH'(1);
      end
    end
  end
endmodule : arl_avg

/* design/arl_cmp.sv */
// one-sided limit compare for a single channel
`timescale 1ns/1ps
module arl_cmp import arl_pkg::*; #(
  parameter int RES_W = ARL_RES_W
) (
  // operands
  input wire logic [RES_W-1:0] value,
  input wire logic [RES_W-1:0] limit,
  input wire logic over_limit_check,
  // result
  output logic fault
);
  // a single limit per channel, so no window check is possible
  assign fault = over_limit_check ? (value > limit) : (value < limit);
endmodule : arl_cmp

/* design/arl_top.sv */
// readback converter sequencer with per-channel limits and warnings
//
// How it works
// (R1) Each conversion result is kept as a 12-bit unsigned code readable per channel.
// (R2) With averaging on, 16 back-to-back conversions are taken and their mean is the result.
// (R3) A single-shot read reports one result for every selected channel and then stops.
// (R4) A continuous read keeps stepping through the selected channels, wrapping, until a stop.
// (R5) Channels whose enable is clear are skipped by the round robin.
// (R6) Each channel has its own limit and every new result is compared against it.
// (R7) With the over check selected, a reading above the limit sets the channel fault.
// (R8) With the under check selected, a reading below the limit sets the channel fault.
// (R9) Each channel holds one limit and one direction, so no window fault exists.
// (R10) The warnings signal is the OR of all its fault inputs.
// (R11) That OR takes the five supply detector statuses and every channel limit fault.
// (R12) Warnings go to the sequencing engine as a selectable state exit condition.
// (R13) Twelve sources share the converter, one channel selected at a time.
// (R14) The limit compare uses the final reported result, so the averaged value when averaging.
`timescale 1ns/1ps
module arl_top import arl_pkg::*; #(
  parameter int NCH = ARL_NCH,
  parameter int CH_W = ARL_CH_W,
  parameter int RES_W = ARL_RES_W
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // register port
  input wire logic [ARL_ADDR_W-1:0] ADDR,
  input wire logic [ARL_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [ARL_DATA_W-1:0] RDATA,
  // converter
  output logic ADC_START,
  output logic [CH_W-1:0] ADC_CHANNEL,
  input wire logic ADC_DONE,
  input wire logic [RES_W-1:0] ADC_DATA,
  // supply detector statuses: positive supply inputs 0..3, high voltage input 4
  input wire logic [ARL_NSUP-1:0] SUPPLY_FAULT,
  // outputs to the system
  output logic WARNINGS,
  output logic SEQ_EXIT,
  output logic IRQ,
  output logic BUSY
);
  ////////////////////////////////////////////////////////////////////////////
  // state
  arl_state_t state;
  logic [CH_W-1:0] ch;
  logic cont;
  logic avg_en;
  logic warn_sel;
  logic stop_pend;
  logic [NCH-1:0] chan_en;
  logic [NCH-1:0] limit_dir;
  logic [NCH-1:0] fault;
  logic [RES_W-1:0] results [NCH];
  logic [RES_W-1:0] limits [NCH];
  logic [ARL_NIRQ-1:0] irq_status;
  logic [ARL_NIRQ-1:0] irq_mask;

  // lowest enabled channel at or above lo, with a found flag in the top bit
  function automatic logic [CH_W:0] find_ge(input logic [NCH-1:0] en, input logic [CH_W:0] lo);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en[i] && ((CH_W+1)'(i) >= lo)) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction : find_ge

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire [1:0] region = ADDR[7:6];
  wire [CH_W-1:0] aidx = ADDR[CH_W+1:2];
  wire idx_ok = (aidx < CH_W'(NCH)) && (ADDR[1:0] == 2'h0);
  wire wr_ctrl = WR && (ADDR == ARL_OFF_CTRL);
  wire wr_en = WR && (ADDR == ARL_OFF_CHAN_EN);
  wire wr_dir = WR && (ADDR == ARL_OFF_LIMIT_DIR);
  wire wr_mask = WR && (ADDR == ARL_OFF_IRQ_MASK);
  wire wr_limit = WR && (region == ARL_REGION_LIMIT) && idx_ok;
  wire rd_irq = RD && (ADDR == ARL_OFF_IRQ_STATUS);
  wire start_req = wr_ctrl && WDATA[ARL_CTRL_START];
  wire stop_req = wr_ctrl && WDATA[ARL_CTRL_STOP];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer decisions
  wire [CH_W:0] first = find_ge(chan_en, '0);
  wire [CH_W:0] nxt = find_ge(chan_en, {1'b0, ch} + (CH_W+1)'(1));
  wire sample_valid = (state == ARL_ST_WAIT) && ADC_DONE;
  wire avg_last;
  wire [RES_W-1:0] avg_mean;
  wire store = sample_valid && avg_last;
  wire avg_clear = (state == ARL_ST_IDLE) || (state == ARL_ST_NEXT);
  wire end_single = (state == ARL_ST_NEXT) && !nxt[CH_W] && (!cont || !first[CH_W]);
  wire [NCH-1:0] cmp_fault;
  wire fault_rise = store && cmp_fault[ch] && !fault[ch];
  // a stop that lands on the last channel's final step still suppresses the done event
  wire [ARL_NIRQ-1:0] irq_event = {store, fault_rise, end_single && !stop_pend && !stop_req};
  wire [ARL_NIRQ-1:0] next_irq_status = (irq_status & ~{ARL_NIRQ{rd_irq}}) | irq_event;
  // the output follows a mask write in the same cycle as the mask itself
  wire [ARL_NIRQ-1:0] next_irq_mask = wr_mask ? WDATA[ARL_NIRQ-1:0] : irq_mask;
  wire next_warnings = (|fault) || (|SUPPLY_FAULT); // see (R10) see (R11)

  arl_avg #(.RES_W(RES_W), .N(ARL_AVG_N)) u_avg (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .clear(avg_clear),
    .avg_en(avg_en),
    .sample_valid(sample_valid),
    .sample(ADC_DATA),
    .last(avg_last),
    .mean(avg_mean)
  ); // see (R2) see (R14)

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_cmp
      // every channel compares the freshly reported value against its own limit
      arl_cmp #(.RES_W(RES_W)) u_cmp (
        .value(avg_mean),
        .limit(limits[gi]),
        .over_limit_check(limit_dir[gi]),
        .fault(cmp_fault[gi])
      ); // see (R6) see (R7) see (R8) see (R9)
      always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
          results[gi] <= '0;
          limits[gi] <= ARL_RST_LIMIT;
          fault[gi] <= 1'b0;
        end else if (CE) begin
          if (store && (ch == CH_W'(gi))) begin
            results[gi] <= avg_mean; // see (R1)
            fault[gi] <= cmp_fault[gi]; // see (R14)
          end
          if (wr_limit && (aidx == CH_W'(gi))) begin
            limits[gi] <= WDATA[RES_W-1:0];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: one channel on the converter at a time
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ARL_ST_IDLE;
      ch <= '0;
      stop_pend <= 1'b0;
      ADC_START <= 1'b0;
    end else if (CE) begin
      ADC_START <= (state == ARL_ST_CONV); // see (R13)
      if (stop_req) begin
        stop_pend <= (state != ARL_ST_IDLE);
      end
      case (state)
        ARL_ST_IDLE: begin
          // start with nothing enabled does nothing
          if (start_req && first[CH_W]) begin
            ch <= first[CH_W-1:0];
            state <= ARL_ST_CONV;
          end
        end
        ARL_ST_CONV: begin
          state <= ARL_ST_WAIT;
        end
        ARL_ST_WAIT: begin
          if (sample_valid) begin
            state <= avg_last ? ARL_ST_NEXT : ARL_ST_CONV; // see (R2)
          end
        end
        ARL_ST_NEXT: begin
          // a stop lets the running conversion finish so the converter is never cut short
          if (stop_pend || stop_req) begin
            state <= ARL_ST_IDLE;
            stop_pend <= 1'b0;
          end else if (nxt[CH_W]) begin
            ch <= nxt[CH_W-1:0]; // see (R5)
            state <= ARL_ST_CONV;
          end else if (cont && first[CH_W]) begin
            ch <= first[CH_W-1:0]; // see (R4)
            state <= ARL_ST_CONV;
          end else begin
            state <= ARL_ST_IDLE; // see (R3)
          end
        end
        default: begin
          state <= ARL_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers, interrupt and outputs
  wire [ARL_DATA_W-1:0] rd_value =
    (ADDR == ARL_OFF_CTRL) ? ARL_DATA_W'({warn_sel, 1'b0, avg_en, cont, 1'b0}) :
    (ADDR == ARL_OFF_CHAN_EN) ? ARL_DATA_W'(chan_en) :
    (ADDR == ARL_OFF_LIMIT_DIR) ? ARL_DATA_W'(limit_dir) :
    (ADDR == ARL_OFF_STATUS) ? ARL_DATA_W'({ch, stop_pend, state != ARL_ST_IDLE}) :
    (ADDR == ARL_OFF_IRQ_STATUS) ? ARL_DATA_W'(irq_status) :
    (ADDR == ARL_OFF_IRQ_MASK) ? ARL_DATA_W'(irq_mask) :
    (ADDR == ARL_OFF_FAULTS) ? ARL_DATA_W'(fault) :
    (ADDR == ARL_OFF_WARN) ? ARL_DATA_W'({SUPPLY_FAULT, WARNINGS}) :
    ((region == ARL_REGION_RESULT) && idx_ok) ? ARL_DATA_W'(results[aidx]) :
    ((region == ARL_REGION_LIMIT) && idx_ok) ? ARL_DATA_W'(limits[aidx]) :
    '0;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cont <= 1'b0;
      avg_en <= 1'b0;
      warn_sel <= 1'b0;
      chan_en <= ARL_RST_CHAN_EN;
      limit_dir <= ARL_RST_LIMIT_DIR;
      irq_mask <= ARL_RST_IRQ_MASK;
      irq_status <= '0;
      RDATA <= '0;
      IRQ <= 1'b0;
      WARNINGS <= 1'b0;
      SEQ_EXIT <= 1'b0;
      BUSY <= 1'b0;
    end else if (CE) begin
      if (wr_ctrl) begin
        cont <= WDATA[ARL_CTRL_CONT];
        avg_en <= WDATA[ARL_CTRL_AVG];
        warn_sel <= WDATA[ARL_CTRL_WSEL];
      end
      if (wr_en) begin
        chan_en <= WDATA[NCH-1:0];
      end
      if (wr_dir) begin
        limit_dir <= WDATA[NCH-1:0];
      end
      irq_mask <= next_irq_mask;
      // an event in the clearing read cycle survives the clear
      irq_status <= next_irq_status;
      RDATA <= RD ? rd_value : '0;
      IRQ <= |(next_irq_status & next_irq_mask);
      WARNINGS <= next_warnings;
      SEQ_EXIT <= next_warnings && warn_sel; // see (R12)
      BUSY <= (state != ARL_ST_IDLE);
    end
  end
  assign ADC_CHANNEL = ch;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [4:0] samp_cnt;
  logic [NCH-1:0] chan_en_q;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      samp_cnt <= '0;
      chan_en_q <= '0;
    end else if (CE) begin
      chan_en_q <= chan_en;
      if (avg_clear) begin
        samp_cnt <= '0;
      end else if (sample_valid && (samp_cnt != 5'h1F)) begin
        samp_cnt <= samp_cnt + 5'h01;
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  chk_result_store: assert property (CE && store |=> results[ch] == $past(avg_mean)) // see (R1)
    else $error("stored result differs from reported value");
  chk_avg_count: assert property (CE && store && avg_en |-> samp_cnt >= 5'h0F) // see (R2)
    else $error("averaged result after fewer than sixteen samples");
  chk_single_stop: assert property (CE && end_single && !stop_req |=> state == ARL_ST_IDLE) // see (R3)
    else $error("single shot did not stop after last channel");
  chk_cont_wrap: assert property (CE && (state == ARL_ST_NEXT) && cont && !stop_pend && !stop_req
      && !nxt[CH_W] && first[CH_W] |=> state == ARL_ST_CONV && ch == $past(first[CH_W-1:0])) // see (R4)
    else $error("continuous read did not wrap to first channel");
  chk_skip_disabled: assert property (CE && (state == ARL_ST_CONV) |-> chan_en_q[ch] || !$past(CE)
      || $past(state) == ARL_ST_WAIT || $past(state) == ARL_ST_CONV) // see (R5)
    else $error("disabled channel entered the round robin");
  chk_limit_fault: assert property (CE && store |=> fault[ch] == (limit_dir[ch] ?
      (results[ch] > limits[ch]) : (results[ch] < limits[ch]))) // see (R6) see (R7) see (R8) see (R14)
    else $error("channel fault does not match result against limit");
  chk_warn_or: assert property (CE |=> WARNINGS == ($past(|fault) || $past(|SUPPLY_FAULT))) // see (R10) see (R11)
    else $error("warnings is not the OR of its inputs");
  chk_seq_exit: assert property (CE |=> SEQ_EXIT == (WARNINGS && $past(warn_sel))) // see (R12)
    else $error("state exit condition does not follow warnings and select");
  chk_start_pulse: assert property (CE && ADC_START |-> state == ARL_ST_WAIT ##1 !ADC_START || !CE) // see (R13)
    else $error("converter start is not a single pulse");
  chk_irq_level: assert property (CE |=> IRQ == |(irq_status & irq_mask))
    else $error("interrupt output does not follow masked status");
  chk_ce_freeze: assert property (!CE |=> $stable(state) && $stable(irq_status) && $stable(RDATA))
    else $error("state moved while the clock enable was low");

  cov_single_done: cover property (CE && end_single && !stop_pend);
  cov_cont_wrap: cover property (CE && (state == ARL_ST_NEXT) && cont && !nxt[CH_W] && first[CH_W]);
  cov_avg_store: cover property (CE && store && avg_en);
  cov_fault_rise: cover property (CE && fault_rise);
endmodule : arl_top

/* shared/arl_pkg.sv */
// shared constants for the readback and limit warning block
package arl_pkg;
  localparam int ARL_NCH = 12;
  localparam int ARL_CH_W = 4;
  localparam int ARL_RES_W = 12;
  localparam int ARL_AVG_N = 16;
  localparam int ARL_NSUP = 5;
  localparam int ARL_ADDR_W = 8;
  localparam int ARL_DATA_W = 16;
  // register offsets (byte addresses)
  localparam logic [7:0] ARL_OFF_CTRL = 8'h00;
  localparam logic [7:0] ARL_OFF_CHAN_EN = 8'h04;
  localparam logic [7:0] ARL_OFF_LIMIT_DIR = 8'h08;
  localparam logic [7:0] ARL_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ARL_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ARL_OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] ARL_OFF_FAULTS = 8'h18;
  localparam logic [7:0] ARL_OFF_WARN = 8'h1C;
  localparam logic [1:0] ARL_REGION_RESULT = 2'h1;
  localparam logic [1:0] ARL_REGION_LIMIT = 2'h2;
  // control register fields
  localparam int ARL_CTRL_START = 0;
  localparam int ARL_CTRL_CONT = 1;
  localparam int ARL_CTRL_AVG = 2;
  localparam int ARL_CTRL_STOP = 3;
  localparam int ARL_CTRL_WSEL = 4;
  // interrupt status fields
  localparam int ARL_IRQ_DONE = 0;
  localparam int ARL_IRQ_FAULT = 1;
  localparam int ARL_IRQ_RESULT = 2;
  localparam int ARL_NIRQ = 3;
  // reset values
  localparam logic [11:0] ARL_RST_CHAN_EN = 12'h000;
  localparam logic [11:0] ARL_RST_LIMIT_DIR = 12'h000;
  localparam logic [11:0] ARL_RST_LIMIT = 12'h000;
  localparam logic [2:0] ARL_RST_IRQ_MASK = 3'h0;
  typedef enum logic [1:0] {
    ARL_ST_IDLE = 2'b00,
    ARL_ST_CONV = 2'b01,
    ARL_ST_WAIT = 2'b11,
    ARL_ST_NEXT = 2'b10
  } arl_state_t;
endpackage : arl_pkg

/* testbench/arl_top_test.sv */
// self-checking bench for the readback sequencer, limits and warnings
`timescale 1ns/1ps
module arl_top_test;
  import arl_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ARL_ADDR_W-1:0] addr = 8'h00;
  logic [ARL_DATA_W-1:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [ARL_DATA_W-1:0] rdata;
  logic ce = 1'b1;
  logic adc_start;
  logic [ARL_CH_W-1:0] adc_channel;
  logic adc_done = 1'b0;
  logic [ARL_RES_W-1:0] adc_data = 12'h000;
  logic [ARL_NSUP-1:0] supply_fault = 5'h00;
  logic warnings, seq_exit, irq, busy;
  logic [11:0] en_m = 12'h000;
  logic avg_on = 1'b0;
  logic [3:0] k = 4'h0;
  logic [ARL_CH_W-1:0] seq[$];
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] v;

  arl_top arl_top_i (.CLK(clk), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .ADC_START(adc_start), .ADC_CHANNEL(adc_channel), .ADC_DONE(adc_done), .ADC_DATA(adc_data),
    .SUPPLY_FAULT(supply_fault), .WARNINGS(warnings), .SEQ_EXIT(seq_exit), .IRQ(irq), .BUSY(busy));

  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // hang guard, well above the longest run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // converter stand-in: one answer per start, data line scrambled between answers
  always @(posedge clk) begin
    adc_done <= adc_start;
    adc_data <= adc_start ? 12'h100 + {4'h0, adc_channel, 4'h0} + {8'h00, k} : ~adc_data;
    if (adc_done) begin
      k <= avg_on ? k + 4'h1 : 4'h0;
    end
    if (adc_start) begin
      seq.push_back(adc_channel);
      chk({15'h0, en_m[adc_channel]}, 16'h0001, "disabled channel converted");
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // taken at the edge that ends the data cycle, before the design clears it
    @(posedge clk);
    d = rdata;
  endtask : rd_reg

  task wait_idle;
    int n;
    repeat (3) @(posedge clk);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk({15'h0, busy}, 16'h0000, "sequencer never went idle");
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////
  task test_reset_map;
    rd_reg(ARL_OFF_CHAN_EN, v);
    chk(v, {4'h0, ARL_RST_CHAN_EN}, "chan enable reset");
    rd_reg(ARL_OFF_LIMIT_DIR, v);
    chk(v, {4'h0, ARL_RST_LIMIT_DIR}, "direction reset");
    rd_reg(8'h84, v);
    chk(v, {4'h0, ARL_RST_LIMIT}, "limit reset");
    rd_reg(ARL_OFF_IRQ_MASK, v);
    chk(v, {13'h0, ARL_RST_IRQ_MASK}, "mask reset");
    wr_reg(8'h30, 16'hFFFF);
    rd_reg(8'h30, v);
    chk(v, 16'h0000, "unmapped read");
    ce <= 1'b0;
    wr_reg(ARL_OFF_CHAN_EN, 16'h0FFF);
    ce <= 1'b1;
    rd_reg(ARL_OFF_CHAN_EN, v);
    chk(v, 16'h0000, "write ignored while frozen");
  endtask : test_reset_map

  // every detector status alone must raise the warnings and, when selected, the exit
  task test_supply;
    for (int i = 0; i < ARL_NSUP; i++) begin
      wr_reg(ARL_OFF_CTRL, 16'h0000);
      supply_fault <= 5'h01 << i;
      repeat (3) @(posedge clk);
      chk({14'h0, warnings, seq_exit}, 16'h0002, "supply warning");
      wr_reg(ARL_OFF_CTRL, 16'h0010);
      repeat (2) @(posedge clk);
      chk({15'h0, seq_exit}, 16'h0001, "selected exit");
      rd_reg(ARL_OFF_CTRL, v);
      chk(v, 16'h0010, "control readback");
      rd_reg(ARL_OFF_WARN, v);
      chk(v, {10'h0, 5'h01 << i, 1'b1}, "warn register");
      supply_fault <= 5'h00;
      repeat (3) @(posedge clk);
      chk({14'h0, warnings, seq_exit}, 16'h0000, "warning clears");
    end
    wr_reg(ARL_OFF_CTRL, 16'h0000);
  endtask : test_supply

  // ch0 over check at its own reading, ch2 under check just above its reading
  task test_single;
    wr_reg(8'h80, 16'h0100);
    wr_reg(8'h88, 16'h0121);
    wr_reg(ARL_OFF_LIMIT_DIR, 16'h0001);
    en_m = 12'h005;
    wr_reg(ARL_OFF_CHAN_EN, 16'h0005);
    wr_reg(ARL_OFF_IRQ_MASK, 16'h0001);
    seq.delete();
    wr_reg(ARL_OFF_CTRL, 16'h0001);
    wait_idle();
    chk(16'(seq.size()), 16'h0002, "single shot count");
    chk({12'h0, seq[0]}, 16'h0000, "first channel");
    chk({12'h0, seq[1]}, 16'h0002, "second channel");
    rd_reg(8'h40, v);
    chk(v, 16'h0100, "result ch0");
    rd_reg(8'h48, v);
    chk(v, 16'h0120, "result ch2");
    rd_reg(ARL_OFF_FAULTS, v);
    chk(v, 16'h0004, "faults equal and under");
    chk({14'h0, warnings, irq}, 16'h0003, "warning and done irq");
    rd_reg(ARL_OFF_IRQ_STATUS, v);
    chk(v, 16'h0007, "irq status");
    repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0000, "irq after clearing read");
  endtask : test_single

  // sixteen samples base..base+15, mean base+7 flips both faults
  task test_average;
    wr_reg(ARL_OFF_IRQ_MASK, 16'h0000);
    avg_on = 1'b1;
    seq.delete();
    wr_reg(ARL_OFF_CTRL, 16'h0005);
    wait_idle();
    chk(16'(seq.size()), 16'h0020, "sixteen samples each");
    rd_reg(8'h40, v);
    chk(v, 16'h0107, "mean ch0");
    rd_reg(8'h48, v);
    chk(v, 16'h0127, "mean ch2");
    rd_reg(ARL_OFF_FAULTS, v);
    chk(v, 16'h0001, "faults on mean");
    chk({15'h0, irq}, 16'h0000, "masked irq stays low");
    rd_reg(ARL_OFF_IRQ_STATUS, v);
    chk(v, 16'h0007, "irq status avg");
    avg_on = 1'b0;
  endtask : test_average

  task test_continuous;
    int n;
    en_m = 12'h802;
    wr_reg(ARL_OFF_CHAN_EN, 16'h0802);
    seq.delete();
    wr_reg(ARL_OFF_CTRL, 16'h0003);
    n = 0;
    while (seq.size() < 5 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk({15'h0, busy}, 16'h0001, "busy while running");
    rd_reg(ARL_OFF_STATUS, v);
    chk(v & 16'h0003, 16'h0001, "status running, no stop");
    wr_reg(ARL_OFF_CTRL, 16'h000A);
    wait_idle();
    chk({15'h0, 1'(seq.size() >= 5)}, 16'h0001, "kept running");
    for (int i = 0; i < 5; i++) begin
      chk({12'h0, seq[i]}, (i % 2) ? 16'h000B : 16'h0001, "round robin order");
    end
    rd_reg(8'h6C, v);
    chk(v, 16'h01B0, "result ch11");
    rd_reg(ARL_OFF_IRQ_STATUS, v);
    chk(v, 16'h0004, "stop gives no done");
  endtask : test_continuous
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    test_reset_map();
    test_supply();
    test_single();
    test_average();
    test_continuous();
    complete_run();
  end
endmodule : arl_top_test
